/* fgp_pkg.sv */
// package for the five bit port: register offsets, field positions, reset values
package fgp_pkg;
	localparam int FGP_PINS = 5;
	localparam logic [7:0] FGP_OFS_DATA = 8'h00;
	localparam logic [7:0] FGP_OFS_OE = 8'h04;
	localparam logic [7:0] FGP_OFS_FS1 = 8'h08;
	localparam logic [7:0] FGP_OFS_FS3 = 8'h10;
	localparam logic [7:0] FGP_OFS_OD = 8'h28;
	localparam logic [7:0] FGP_OFS_PU = 8'h2c;
	localparam logic [7:0] FGP_OFS_IE = 8'h38;
	localparam logic [7:0] FGP_OFS_STOP = 8'h3c;
	// writable bit masks of the function selects
	localparam logic [4:0] FGP_FS1_MASK = 5'h03;
	localparam logic [4:0] FGP_FS3_MASK = 5'h1c;
	// field positions
	localparam int FGP_FS1_TRACE2 = 0;
	localparam int FGP_FS1_TRACE3 = 1;
	localparam int FGP_FS3_TMR4 = 2;
	localparam int FGP_FS3_TMR5 = 3;
	localparam int FGP_FS3_EXTERNAL_INTERRUPT_EIGHT = 4;
	localparam logic [4:0] FGP_RST = 5'h00;
	typedef struct packed {
		logic [4:0] data;
		logic [4:0] oe;
		logic [4:0] fs1;
		logic [4:0] fs3;
		logic [4:0] od;
		logic [4:0] pu;
		logic [4:0] ie;
		logic stop;
		logic ack;
		logic [31:0] rdat;
	} fgp_state_t;
endpackage : fgp_pkg

/* fgp_port.sv */
// five bit gpio port with alternate function mux and wishbone registers
`timescale 1ns/10ps
`default_nettype none
module fgp_port
	import fgp_pkg::*;
(
	// system
	input wire logic clk,
	input wire logic reset_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// port pins, five signals each
	input wire logic [4:0] port_pins_i,
	output logic [4:0] port_pins_o,
	output logic [4:0] port_pins_oe,
	output logic [4:0] port_pins_pu,
	output logic [4:0] port_pins_ie,
	// alternate function peripherals
	input wire logic trace_line_two,
	input wire logic trace_line_three,
	input wire logic timer_four_output,
	input wire logic timer_five_output,
	output logic external_interrupt_eight,
	// stop low-power mode indication
	output logic stop_mode
);
	fgp_state_t st_ff;
	fgp_state_t nxt_st;
	logic req;
	logic hit;
	logic [4:0] alt_sel;
	logic [4:0] alt_val;
	logic [4:0] out_val;
	logic [4:0] drv_en;

	function automatic logic [4:0] wr5(input logic [4:0] old, input logic [31:0] d,
		input logic [3:0] sel, input logic [4:0] mask);
		wr5 = sel[0] ? (d[4:0] & mask) : old;
	endfunction : wr5

	assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
	always_comb begin
		unique case (wb_adr_i)
			FGP_OFS_DATA, FGP_OFS_OE, FGP_OFS_FS1, FGP_OFS_FS3,
			FGP_OFS_OD, FGP_OFS_PU, FGP_OFS_IE, FGP_OFS_STOP: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// alternate function mux: the disjoint FS1 and FS3 masks give each pin at most one function
	always_comb begin
		alt_sel = (st_ff.fs1 & FGP_FS1_MASK) | (st_ff.fs3 & FGP_FS3_MASK);
		alt_val = 5'h00;
		alt_val[0] = trace_line_two;
		alt_val[1] = trace_line_three;
		alt_val[2] = timer_four_output;
		alt_val[3] = timer_five_output;
		// the interrupt pin is an input function, it never drives
		alt_sel[FGP_FS3_EXTERNAL_INTERRUPT_EIGHT] = 1'b0;
		out_val = (alt_sel & alt_val) | (~alt_sel & st_ff.data);
	end

	// per-pin driver: open-drain drives only low
	always_comb begin
		drv_en = st_ff.oe & ~(st_ff.od & out_val);
		port_pins_o = out_val & ~st_ff.od;
		port_pins_oe = drv_en;
		port_pins_pu = st_ff.pu;
		port_pins_ie = st_ff.ie;
		// interrupt passes regardless of function select
		external_interrupt_eight = st_ff.ie[FGP_FS3_EXTERNAL_INTERRUPT_EIGHT] && !st_ff.stop
			&& port_pins_i[FGP_FS3_EXTERNAL_INTERRUPT_EIGHT];
		stop_mode = st_ff.stop;
		wb_dat_o = st_ff.rdat;
		wb_ack_o = st_ff.ack;
		wb_err_o = 1'b0;
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = req;
		if (req && wb_we_i && hit) begin
			unique case (wb_adr_i)
				FGP_OFS_DATA: nxt_st.data = wr5(st_ff.data, wb_dat_i, wb_sel_i, 5'h1f);
				FGP_OFS_OE: nxt_st.oe = wr5(st_ff.oe, wb_dat_i, wb_sel_i, 5'h1f);
				FGP_OFS_FS1: nxt_st.fs1 = wr5(st_ff.fs1, wb_dat_i, wb_sel_i, FGP_FS1_MASK);
				FGP_OFS_FS3: nxt_st.fs3 = wr5(st_ff.fs3, wb_dat_i, wb_sel_i, FGP_FS3_MASK);
				FGP_OFS_OD: nxt_st.od = wr5(st_ff.od, wb_dat_i, wb_sel_i, 5'h1f);
				FGP_OFS_PU: nxt_st.pu = wr5(st_ff.pu, wb_dat_i, wb_sel_i, 5'h1f);
				FGP_OFS_IE: nxt_st.ie = wr5(st_ff.ie, wb_dat_i, wb_sel_i, 5'h1f);
				default: begin
					if (wb_sel_i[0])
						nxt_st.stop = wb_dat_i[0];
				end
			endcase
		end
		nxt_st.rdat = 32'h0000_0000;
		if (req && !wb_we_i && hit) begin
			unique case (wb_adr_i)
				// pins read where input enabled, else zero
				FGP_OFS_DATA: nxt_st.rdat[4:0] = port_pins_i & st_ff.ie;
				FGP_OFS_OE: nxt_st.rdat[4:0] = st_ff.oe;
				FGP_OFS_FS1: nxt_st.rdat[4:0] = st_ff.fs1;
				FGP_OFS_FS3: nxt_st.rdat[4:0] = st_ff.fs3;
				FGP_OFS_OD: nxt_st.rdat[4:0] = st_ff.od;
				FGP_OFS_PU: nxt_st.rdat[4:0] = st_ff.pu;
				FGP_OFS_IE: nxt_st.rdat[4:0] = st_ff.ie;
				default: nxt_st.rdat[0] = st_ff.stop;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule : fgp_port
`default_nettype wire

/* fgp_assertions.sv */
// checker of the five bit port
`timescale 1ns/10ps
`default_nettype none
module fgp_assertions (
	// watched ports
	input wire logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, stop_mode,
	input wire logic external_interrupt_eight,
	input wire logic [31:0] wb_dat_o,
	input wire logic [4:0] port_pins_i, port_pins_oe, port_pins_pu, port_pins_ie
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_one: assert property (p_one) else $error("ack long");
	property p_rst; $rose(reset_n) |-> !(port_pins_oe | port_pins_pu | port_pins_ie); endproperty
	a_rst: assert property (p_rst) else $error("pins on");
	property p_int; external_interrupt_eight == (port_pins_i[4] && port_pins_ie[4] && !stop_mode);
	endproperty
	a_int: assert property (p_int) else $error("irq");
	property p_pu; !wb_cyc_i |=> $stable(port_pins_pu); endproperty
	a_pu: assert property (p_pu) else $error("pu moved");
	property p_ie; !wb_cyc_i |=> $stable(port_pins_ie); endproperty
	a_ie: assert property (p_ie) else $error("ie moved");
	property p_hi; wb_dat_o[31:5] == 27'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper bits");
	property p_err; !wb_err_o; endproperty
	a_err: assert property (p_err) else $error("err");
endmodule : fgp_assertions
`default_nettype wire

/* fgp_pins_model.sv */
// pin levels seen by the port
`timescale 1ns/10ps
`default_nettype none
module fgp_pins_model (
	input wire logic clk,
	input wire logic [4:0] port_pins_o, port_pins_oe, port_pins_pu,
	output logic [4:0] port_pins_i
);
	logic t = 1'b0;
	// floating pins toggle so a stale level never passes
	always @(posedge clk) t <= ~t;
	assign port_pins_i = port_pins_oe & port_pins_o | ~port_pins_oe & (port_pins_pu | {5{t}});
endmodule : fgp_pins_model
`default_nettype wire

/* fgp_port_tb_top.sv */
// testbench of the five bit port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t bad %h", $time, a); end end
module fgp_port_tb_top;
	logic clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, wb_err_o;
	logic trace_line_two = 0, trace_line_three = 0, timer_four_output = 0, timer_five_output = 0;
	logic external_interrupt_eight, stop_mode;
	logic [7:0] wb_adr_i = 8'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r, d;
	logic [4:0] port_pins_i, port_pins_o, port_pins_oe, port_pins_pu, port_pins_ie;
	int n_errors = 0, samples_checked = 0;
	// mapped locations only, reserved holes are never touched
	logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h28, 8'h2c, 8'h38, 8'h3c};
	logic [4:0] msk[8] = '{5'h00, 5'h1f, 5'h03, 5'h1c, 5'h1f, 5'h1f, 5'h1f, 5'h01};
	fgp_port fgp_port_i (.*, .wb_sel_i(4'hf));
	fgp_pins_model fgp_pins_model_i (.*);
	initial forever #2.5 clk = ~clk;
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, v};
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		r = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clk);
	endtask : wb
	task results;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results
	initial begin
		#20000;
		n_errors++;
		results();
	end
	initial begin
		void'($urandom(5));
		repeat (20) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			wb(0, ofs[i], 32'h0);
			`CHK(r, 32'h0)
			d = $urandom;
			wb(1, ofs[i], d);
			wb(0, ofs[i], 32'h0);
			`CHK(r, {27'h0, d[4:0] & msk[i]})
		end
		$display("registers done");
		for (int i = 1; i < 8; i++) wb(1, ofs[i], (i inside {1, 5, 6}) ? 32'h1f : 32'h0);
		for (int j = 0; j < 2; j++) begin
			d = $urandom;
			wb(1, 8'h28, j ? 32'h1f : 32'h0);
			wb(1, 8'h00, d);
			wb(0, 8'h00, 32'h0);
			`CHK(r, {27'h0, d[4:0]})
			`CHK(port_pins_oe, j ? ~d[4:0] : 5'h1f)
			`CHK(external_interrupt_eight, d[4])
		end
		`CHK(port_pins_pu, 5'h1f)
		`CHK(port_pins_ie, 5'h1f)
		wb(1, 8'h3c, 32'h1);
		`CHK({stop_mode, external_interrupt_eight}, 2'b10)
		wb(1, 8'h3c, 32'h0);
		$display("drive done");
		{timer_five_output, timer_four_output, trace_line_three, trace_line_two} <= 4'($urandom);
		wb(1, 8'h28, 32'h0);
		wb(1, 8'h08, 32'h3);
		wb(1, 8'h10, 32'h1c);
		`CHK(port_pins_o[3:0], {timer_five_output, timer_four_output, trace_line_three, trace_line_two})
		$display("select done");
		reset_n <= 0;
		repeat (2) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		`CHK({port_pins_oe, port_pins_pu, port_pins_ie}, 15'h0000)
		wb(0, 8'h04, 32'h0);
		`CHK(r, 32'h0)
		$display("reset done");
		results();
	end
endmodule : fgp_port_tb_top
bind fgp_port fgp_assertions fgp_assertions_i (.*);
`default_nettype wire
